// ===== ieif_enc_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// incremental encoder sensor model
// ****************************************************************
module ieif_enc_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mv,
  input wire logic dn,
  input wire logic jump,
  input wire logic idx_req,
  input wire logic flt_req,
  output logic trk_a,
  output logic trk_b,
  output logic trk_idx,
  output logic flt
);
  logic [1:0] ph_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_r <= 2'h0;
      trk_idx <= 1'b0;
      flt <= 1'b0;
    end else begin
      if (jump) begin
        ph_r <= ph_r + 2'h2;
      end else if (mv) begin
        ph_r <= dn ? ph_r - 2'h1 : ph_r + 2'h1;
      end
      trk_idx <= idx_req;
      flt <= flt_req;
    end
  end
  // tracks a quarter period apart, a leads b going up
  assign trk_a = ph_r[1] ^ ph_r[0];
  assign trk_b = ph_r[1];
endmodule : ieif_enc_model
`default_nettype wire

// ===== ieif_pkg.sv
`default_nettype none
package ieif_pkg;

  // ****************************************************************
  // register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_LINES = 8'h04;
  localparam logic [7:0] ADR_GEAR = 8'h08;
  localparam logic [7:0] ADR_POS = 8'h0C;
  localparam logic [7:0] ADR_MPOS = 8'h10;
  localparam logic [7:0] ADR_STAT = 8'h14;
  localparam logic [7:0] ADR_MASK = 8'h18;
  localparam logic [7:0] ADR_CODE = 8'h1C;
  localparam logic [7:0] ADR_ACT = 8'h20;

  // ****************************************************************
  // control fields
  // ****************************************************************
  localparam int CTRL_EN = 0;
  localparam int CTRL_DIR = 1;
  localparam int CTRL_IDX = 2;
  localparam int CTRL_ERRM = 3;
  localparam int CTRL_KIND = 5;
  localparam int CTRL_RESTART = 31;
  localparam int CTRL_W = 6;

  // ****************************************************************
  // status fields
  // ****************************************************************
  localparam int ST_DIG = 0;
  localparam int ST_ANA = 1;
  localparam int ST_IDX = 2;
  localparam int ST_MEAS = 3;
  localparam int ST_ILL = 4;
  localparam int STAT_W = 5;

  // ****************************************************************
  // values after reset and codes
  // ****************************************************************
  localparam logic [5:0] CTRL_RST = 6'h05;
  localparam logic [15:0] LINES_RST = 16'h0800;
  localparam logic [31:0] GEAR_RST = 32'h0001_0000;
  localparam logic [4:0] MASK_RST = 5'h00;
  localparam logic [7:0] ERR_DIG = 8'h84;
  localparam logic [7:0] ERR_ANA = 8'h82;

  typedef enum logic [1:0] {EM_OFF, EM_HIGH, EM_LOW} ieif_errm_t;
  typedef enum logic [1:0] {MS_IDLE, MS_ARMED, MS_DONE} ieif_meas_t;

  // ****************************************************************
  // byte-lane merge for bus writes
  // ****************************************************************
  function automatic logic [31:0] ieif_wmerge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction : ieif_wmerge

endpackage : ieif_pkg
`default_nettype wire

// ===== ieif_quad.sv
`timescale 1ns/1ps
`default_nettype none
module ieif_quad
  import ieif_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic a,
  input wire logic b,
  output logic step,
  output logic up,
  output logic illegal
);

  // ****************************************************************
  // fourfold edge decoder
  // ****************************************************************
  logic [1:0] prev_r;
  logic step_r;
  logic up_r;
  logic ill_r;
  logic [1:0] cur;
  logic [1:0] chg;
  logic step_nxt;
  logic up_nxt;
  logic ill_nxt;

  always_comb begin
    cur = {a, b};
    chg = prev_r ^ cur;
    step_nxt = 1'b0;
    up_nxt = 1'b0;
    ill_nxt = 1'b0;
    if (en) begin // R5
      if (chg == 2'h3) begin
        ill_nxt = 1'b1;
      end else if (chg != 2'h0) begin
        step_nxt = 1'b1; // R2
        up_nxt = prev_r[0] ^ cur[1];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 2'h0;
      step_r <= 1'b0;
      up_r <= 1'b0;
      ill_r <= 1'b0;
    end else begin
      prev_r <= cur;
      step_r <= step_nxt;
      up_r <= up_nxt;
      ill_r <= ill_nxt;
    end
  end

  assign step = step_r;
  assign up = up_r;
  assign illegal = ill_r;

  edge_step_a: assert property (@(posedge clk) disable iff (!rst_n) // R2
    en && (^(prev_r ^ {a, b})) |=> step)
    else $error("single track edge gave no count");

endmodule : ieif_quad
`default_nettype wire

// ===== ieif_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ieif_sync
  import ieif_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] din,
  output logic [3:0] dout
);

  // ****************************************************************
  // two-stage synchroniser
  // ****************************************************************
  logic [3:0] s1_r;
  logic [3:0] s2_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 4'h0;
      s2_r <= 4'h0;
    end else begin
      s1_r <= din; // R14
      s2_r <= s1_r;
    end
  end

  assign dout = s2_r;

  sync_delay_a: assert property (@(posedge clk) disable iff (!rst_n) // R14
    ##2 (dout == $past(din, 2)))
    else $error("synchroniser delay is not two cycles");

endmodule : ieif_sync
`default_nettype wire

// ===== ieif_top.sv
// Behaviour
// R1: encoder gives two tracks quarter period apart
// R2: count every edge of both tracks
// R3: one revolution is four times line count
// R4: direction setting inverts counting sense
// R5: tracks ignored while encoder input disabled
// R6: error input off, high-active or low-active
// R7: active error input raises 08-4 or 08-2
// R8: gear factor scales counts, default one-to-one
// R9: gear factor handles several index pulses
// R10: zero line count measured between index pulses
// R11: new settings act only after restart
// R12: index pulse restores expected index position
// R13: index evaluation can be switched off
// R14: inputs synchronised before edge detection
`timescale 1ns/1ps
`default_nettype none
module ieif_top
  import ieif_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic trk_a,
  input wire logic trk_b,
  input wire logic trk_idx,
  input wire logic encoder_fault_input,
  output logic irq,
  output logic [31:0] enc_pos,
  output logic [31:0] mot_pos,
  output logic [7:0] err_code
);

  // ****************************************************************
  // input synchronisers and decoder
  // ****************************************************************
  logic [3:0] syn;
  logic q_step;
  logic q_up;
  logic q_ill;
  logic en_act_r;

  ieif_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din({encoder_fault_input, trk_idx, trk_b, trk_a}),
    .dout(syn)
  );

  ieif_quad u_quad (
    .clk(clk),
    .rst_n(rst_n),
    .en(en_act_r),
    .a(syn[0]),
    .b(syn[1]),
    .step(q_step),
    .up(q_up),
    .illegal(q_ill)
  );

  // ****************************************************************
  // bus slave state
  // ****************************************************************
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [15:0] lines_r, lines_nxt;
  logic [31:0] gear_r, gear_nxt;
  logic [STAT_W-1:0] mask_r, mask_nxt;
  logic restart_r, restart_nxt;
  logic [STAT_W-1:0] w1c;
  logic hit;
  logic [31:0] wtmp;

  // ****************************************************************
  // core state
  // ****************************************************************
  logic en_act_nxt;
  logic dir_act_r, dir_act_nxt;
  logic idx_act_r, idx_act_nxt;
  logic kind_act_r, kind_act_nxt;
  ieif_errm_t errm_act_r, errm_act_nxt;
  logic [15:0] lines_act_r, lines_act_nxt;
  logic signed [31:0] gear_act_r, gear_act_nxt;
  logic signed [31:0] pos_r, pos_nxt;
  logic [31:0] mpos_r, mpos_nxt;
  logic [17:0] angle_r, angle_nxt;
  logic [17:0] mcnt_r, mcnt_nxt;
  ieif_meas_t meas_r, meas_nxt;
  logic [STAT_W-1:0] stat_r, stat_nxt;
  logic [7:0] code_r, code_nxt;
  logic irq_r, irq_nxt;
  logic idx_prev_r;
  logic idx_evt;
  logic up_eff;
  logic fault_on;
  logic [17:0] rev;
  logic signed [18:0] aerr;
  logic signed [63:0] prod;

  // ****************************************************************
  // bus decode and pending settings
  // ****************************************************************
  always_comb begin
    hit = wb_cyc_i & wb_stb_i & ~ack_r;
    ack_nxt = hit;
    dat_nxt = dat_r;
    ctrl_nxt = ctrl_r;
    lines_nxt = lines_r;
    gear_nxt = gear_r;
    mask_nxt = mask_r;
    restart_nxt = 1'b0;
    w1c = '0;
    wtmp = 32'h0000_0000;
    if (hit && wb_we_i) begin
      case (wb_adr_i)
        ADR_CTRL: begin
          wtmp = ieif_wmerge({26'h0, ctrl_r}, wb_dat_i, wb_sel_i);
          ctrl_nxt = wtmp[CTRL_W-1:0]; // R11
          restart_nxt = wb_sel_i[3] & wb_dat_i[CTRL_RESTART];
        end
        ADR_LINES: begin
          wtmp = ieif_wmerge({16'h0, lines_r}, wb_dat_i, wb_sel_i);
          lines_nxt = wtmp[15:0];
        end
        ADR_GEAR: gear_nxt = ieif_wmerge(gear_r, wb_dat_i, wb_sel_i);
        ADR_STAT: begin
          wtmp = ieif_wmerge(32'h0000_0000, wb_dat_i, wb_sel_i);
          w1c = wtmp[STAT_W-1:0];
        end
        ADR_MASK: begin
          wtmp = ieif_wmerge({27'h0, mask_r}, wb_dat_i, wb_sel_i);
          mask_nxt = wtmp[STAT_W-1:0];
        end
        default: ;
      endcase
    end
    if (hit && !wb_we_i) begin
      case (wb_adr_i)
        ADR_CTRL: dat_nxt = {26'h0, ctrl_r};
        ADR_LINES: dat_nxt = {16'h0, lines_r};
        ADR_GEAR: dat_nxt = gear_r;
        ADR_POS: dat_nxt = pos_r;
        ADR_MPOS: dat_nxt = mpos_r;
        ADR_STAT: dat_nxt = {27'h0, stat_r};
        ADR_MASK: dat_nxt = {27'h0, mask_r};
        ADR_CODE: dat_nxt = {24'h0, code_r};
        ADR_ACT: dat_nxt = {lines_act_r, 10'h0, kind_act_r, errm_act_r,
                            idx_act_r, dir_act_r, en_act_r};
        default: dat_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
      ctrl_r <= CTRL_RST;
      lines_r <= LINES_RST;
      gear_r <= GEAR_RST;
      mask_r <= MASK_RST;
      restart_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      ctrl_r <= ctrl_nxt;
      lines_r <= lines_nxt;
      gear_r <= gear_nxt;
      mask_r <= mask_nxt;
      restart_r <= restart_nxt;
    end
  end

  // ****************************************************************
  // position, index, measurement, faults
  // ****************************************************************
  always_comb begin
    rev = {lines_act_r, 2'b00}; // R3
    up_eff = q_up ^ dir_act_r; // R4
    idx_evt = syn[2] & ~idx_prev_r & en_act_r & idx_act_r; // R13
    if (angle_r < {1'b0, lines_act_r, 1'b0}) begin
      aerr = {1'b0, angle_r};
    end else begin
      aerr = {1'b0, angle_r} - {1'b0, rev};
    end
    case (errm_act_r) // R6
      EM_HIGH: fault_on = syn[3];
      EM_LOW: fault_on = ~syn[3];
      default: fault_on = 1'b0;
    endcase
    fault_on = fault_on & en_act_r;
    prod = pos_r * gear_act_r; // R8 R9
    en_act_nxt = en_act_r;
    dir_act_nxt = dir_act_r;
    idx_act_nxt = idx_act_r;
    kind_act_nxt = kind_act_r;
    errm_act_nxt = errm_act_r;
    lines_act_nxt = lines_act_r;
    gear_act_nxt = gear_act_r;
    pos_nxt = pos_r;
    angle_nxt = angle_r;
    mcnt_nxt = mcnt_r;
    meas_nxt = meas_r;
    stat_nxt = stat_r & ~w1c;
    code_nxt = code_r;
    mpos_nxt = prod[47:16];
    irq_nxt = |(stat_r & mask_r);
    if (restart_r) begin // R11
      en_act_nxt = ctrl_r[CTRL_EN];
      dir_act_nxt = ctrl_r[CTRL_DIR];
      idx_act_nxt = ctrl_r[CTRL_IDX];
      kind_act_nxt = ctrl_r[CTRL_KIND];
      errm_act_nxt = ieif_errm_t'(ctrl_r[CTRL_ERRM +: 2]);
      lines_act_nxt = lines_r;
      gear_act_nxt = gear_r;
      pos_nxt = 32'sh0000_0000;
      angle_nxt = 18'h0_0000;
      mcnt_nxt = 18'h0_0000;
      meas_nxt = MS_IDLE;
    end else begin
      if (idx_evt && lines_act_r != 16'h0000) begin
        pos_nxt = pos_r - {{13{aerr[18]}}, aerr}; // R12
        angle_nxt = 18'h0_0000;
        stat_nxt[ST_IDX] = 1'b1;
      end else if (q_step && en_act_r) begin // R5
        if (up_eff) begin
          pos_nxt = pos_r + 32'sh0000_0001; // R2
          angle_nxt = (angle_r == rev - 18'h0_0001) ? 18'h0_0000
                                                    : angle_r + 18'h0_0001;
        end else begin
          pos_nxt = pos_r - 32'sh0000_0001;
          angle_nxt = (angle_r == 18'h0_0000) ? rev - 18'h0_0001
                                               : angle_r - 18'h0_0001;
        end
      end
      case (meas_r) // R10
        MS_IDLE: begin
          if (idx_evt && lines_act_r == 16'h0000) begin
            meas_nxt = MS_ARMED;
            mcnt_nxt = 18'h0_0000;
          end
        end
        MS_ARMED: begin
          if (idx_evt) begin
            lines_act_nxt = mcnt_r[17:2];
            stat_nxt[ST_MEAS] = 1'b1;
            meas_nxt = MS_DONE;
          end else if (q_step) begin
            mcnt_nxt = mcnt_r + 18'h0_0001;
          end
        end
        MS_DONE: ;
        default: meas_nxt = MS_IDLE;
      endcase
      if (q_ill) begin
        stat_nxt[ST_ILL] = 1'b1;
      end
      if (fault_on) begin // R7
        stat_nxt[kind_act_r ? ST_ANA : ST_DIG] = 1'b1;
        code_nxt = kind_act_r ? ERR_ANA : ERR_DIG;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_act_r <= CTRL_RST[CTRL_EN];
      dir_act_r <= CTRL_RST[CTRL_DIR];
      idx_act_r <= CTRL_RST[CTRL_IDX];
      kind_act_r <= CTRL_RST[CTRL_KIND];
      errm_act_r <= ieif_errm_t'(CTRL_RST[CTRL_ERRM +: 2]);
      lines_act_r <= LINES_RST;
      gear_act_r <= GEAR_RST;
      pos_r <= 32'sh0000_0000;
      mpos_r <= 32'h0000_0000;
      angle_r <= 18'h0_0000;
      mcnt_r <= 18'h0_0000;
      meas_r <= MS_IDLE;
      stat_r <= '0;
      code_r <= 8'h00;
      irq_r <= 1'b0;
      idx_prev_r <= 1'b0;
    end else begin
      en_act_r <= en_act_nxt;
      dir_act_r <= dir_act_nxt;
      idx_act_r <= idx_act_nxt;
      kind_act_r <= kind_act_nxt;
      errm_act_r <= errm_act_nxt;
      lines_act_r <= lines_act_nxt;
      gear_act_r <= gear_act_nxt;
      pos_r <= pos_nxt;
      mpos_r <= mpos_nxt;
      angle_r <= angle_nxt;
      mcnt_r <= mcnt_nxt;
      meas_r <= meas_nxt;
      stat_r <= stat_nxt;
      code_r <= code_nxt;
      irq_r <= irq_nxt;
      idx_prev_r <= syn[2];
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign irq = irq_r;
  assign enc_pos = pos_r;
  assign mot_pos = mpos_r;
  assign err_code = code_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence wb_req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence wb_ans_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  sequence plain_step_s;
    q_step && en_act_r && !restart_r && !idx_evt;
  endsequence

  bus_answer_a: assert property (wb_req_s |=> wb_ans_s)
    else $error("bus request not answered in one cycle");
  count_up_a: assert property (plain_step_s and (q_up && !dir_act_r) // R4
    |=> pos_r == $past(pos_r) + 32'sh0000_0001)
    else $error("forward step did not increment");
  count_inv_a: assert property (plain_step_s and (q_up && dir_act_r) // R4
    |=> pos_r == $past(pos_r) - 32'sh0000_0001)
    else $error("inverted step did not decrement");
  disabled_hold_a: assert property (!en_act_r && !restart_r // R5
    |=> pos_r == $past(pos_r))
    else $error("position moved while disabled");
  rev_wrap_a: assert property (plain_step_s and (up_eff // R3
    && angle_r == rev - 18'h0_0001) |=> angle_r == 18'h0_0000)
    else $error("angle did not wrap at four times line count");
  index_fix_a: assert property (idx_evt && !restart_r // R12
    && lines_act_r != 16'h0000 |=> angle_r == 18'h0_0000)
    else $error("index did not restore angle");
  fault_code_a: assert property (fault_on && !restart_r // R7
    |=> stat_r[$past(kind_act_r) ? ST_ANA : ST_DIG]
    && code_r == ($past(kind_act_r) ? ERR_ANA : ERR_DIG))
    else $error("encoder fault not reported with its code");
  cfg_hold_a: assert property (!restart_r // R11
    |=> $stable(gear_act_r) && $stable(dir_act_r) && $stable(en_act_r))
    else $error("active settings changed without restart");
  meas_lines_a: assert property (meas_r == MS_ARMED && idx_evt // R10
    && !restart_r |=> lines_act_r == $past(mcnt_r[17:2]))
    else $error("measured line count not taken");
  irq_level_a: assert property (|(stat_r & mask_r) && !(|w1c)
    |=> irq ##1 (irq || !(|(stat_r & mask_r)) || (|$past(w1c))))
    else $error("interrupt not raised for unmasked status");

endmodule : ieif_top
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ieif_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, d, p;
  logic ack, irq, mv = 1'b0, dn = 1'b0, jump = 1'b0;
  logic idx_req = 1'b0, flt_req = 1'b0;
  logic ta, tb, ti, flt;
  logic [31:0] enc_pos, mot_pos;
  logic [7:0] err_code;
  int fails = 0, cmp_count = 0, cyc_n = 0;

  always #12.5 clk = ~clk;

  ieif_enc_model i_enc (.clk(clk), .rst_n(rst_n), .mv(mv), .dn(dn),
    .jump(jump), .idx_req(idx_req), .flt_req(flt_req), .trk_a(ta),
    .trk_b(tb), .trk_idx(ti), .flt(flt));

  ieif_top i_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .trk_a(ta),
    .trk_b(tb), .trk_idx(ti), .encoder_fault_input(flt), .irq(irq),
    .enc_pos(enc_pos), .mot_pos(mot_pos), .err_code(err_code));

  // ****************************************************************
  // checks and bus tasks
  // ****************************************************************
  task report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_bit

  task bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= v;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    d = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask : bus

  task rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(d, exp);
  endtask : rdc

  task restart(input logic [31:0] v);
    bus(1'b1, ADR_CTRL, 32'h8000_0000 | v);
    repeat (8) @(posedge clk);
  endtask : restart

  task steps(input int n, input logic down);
    for (int i = 0; i < n; i++) begin
      mv <= 1'b1;
      dn <= down;
      @(posedge clk);
      mv <= 1'b0;
      repeat (4) @(posedge clk);
    end
    repeat (8) @(posedge clk);
  endtask : steps

  task pulse_idx;
    idx_req <= 1'b1;
    @(posedge clk);
    idx_req <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : pulse_idx

  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n > 20000) begin
      fails++;
      report_and_stop();
    end
  end

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdc(ADR_CTRL, 32'h0000_0005);
    rdc(ADR_LINES, 32'h0000_0800);
    rdc(ADR_GEAR, 32'h0001_0000);
    rdc(ADR_ACT, 32'h0800_0005);
    bus(1'b1, 8'h40, 32'hFFFF_FFFF);
    rdc(8'h40, 32'h0);
    steps(8, 1'b0);
    chk(enc_pos, 32'h8);
    chk(mot_pos, 32'h8);
    steps(3, 1'b1);
    chk(enc_pos, 32'h5);
    bus(1'b1, ADR_CTRL, 32'h7);
    steps(4, 1'b0);
    chk(enc_pos, 32'h9);
    rdc(ADR_ACT, 32'h0800_0005);
    bus(1'b1, ADR_GEAR, 32'h0002_0000);
    restart(32'h7);
    chk(enc_pos, 32'h0);
    steps(4, 1'b0);
    chk(enc_pos, 32'hFFFF_FFFC);
    chk(mot_pos, 32'hFFFF_FFF8);
    restart(32'h4);
    steps(4, 1'b0);
    chk(enc_pos, 32'h0);
    restart(32'h1);
    jump <= 1'b1;
    @(posedge clk);
    jump <= 1'b0;
    repeat (8) @(posedge clk);
    chk(enc_pos, 32'h0);
    rdc(ADR_STAT, 32'h10);
    bus(1'b1, ADR_MASK, 32'h1F);
    bus(1'b1, ADR_STAT, 32'h1F);
    restart(32'h9);
    flt_req <= 1'b1;
    repeat (8) @(posedge clk);
    rdc(ADR_STAT, 32'h01);
    rdc(ADR_CODE, 32'h84);
    chk({24'h0, err_code}, 32'h84);
    chk_bit(irq, 1'b1);
    flt_req <= 1'b0;
    repeat (4) @(posedge clk);
    bus(1'b1, ADR_STAT, 32'h01);
    repeat (4) @(posedge clk);
    rdc(ADR_STAT, 32'h0);
    chk_bit(irq, 1'b0);
    restart(32'h31);
    rdc(ADR_STAT, 32'h02);
    rdc(ADR_CODE, 32'h82);
    chk({24'h0, err_code}, 32'h82);
    bus(1'b1, ADR_MASK, 32'h0);
    repeat (4) @(posedge clk);
    chk_bit(irq, 1'b0);
    flt_req <= 1'b1;
    restart(32'h1);
    bus(1'b1, ADR_STAT, 32'h1F);
    flt_req <= 1'b0;
    repeat (8) @(posedge clk);
    rdc(ADR_STAT, 32'h0);
    bus(1'b1, ADR_LINES, 32'h0);
    restart(32'h5);
    pulse_idx();
    steps(12, 1'b0);
    pulse_idx();
    rdc(ADR_ACT, 32'h0003_0005);
    bus(1'b0, ADR_STAT, 32'h0);
    chk_bit(d[ST_MEAS], 1'b1);
    p = enc_pos;
    steps(2, 1'b0);
    pulse_idx();
    chk(enc_pos, p);
    rdc(ADR_STAT, 32'h0C);
    bus(1'b1, ADR_STAT, 32'h1F);
    restart(32'h1);
    steps(1, 1'b0);
    pulse_idx();
    steps(1, 1'b0);
    pulse_idx();
    chk(enc_pos, 32'h2);
    rdc(ADR_STAT, 32'h0);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
